// File: shared/card_reader_pkg.sv
package card_reader_pkg;

	// ****************************************************************
	// equipment addresses
	// ****************************************************************
	localparam logic [15:0] DATA_ADDR = 16'h00E0;
	localparam logic [15:0] DIR_ADDR = 16'h00E1;

	// ****************************************************************
	// function word bits
	// ****************************************************************
	localparam int FN_CLR_CTRL = 0;
	localparam int FN_CLR_INT = 1;
	localparam int FN_SEL_DATA = 2;
	localparam int FN_SEL_EOR = 3;
	localparam int FN_SEL_ALARM = 4;
	localparam int FN_START = 5;
	localparam int FN_STOP = 6;

	// ****************************************************************
	// status word bits
	// ****************************************************************
	localparam int ST_READY = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_INT = 2;
	localparam int ST_DATA = 3;
	localparam int ST_EOR = 4;
	localparam int ST_ALARM = 5;
	localparam int ST_LOST = 6;
	localparam int ST_PROTECT = 7;
	localparam int ST_ABSENT = 8;
	localparam int ST_EMPTY = 9;

	// ****************************************************************
	// card format, reset values and timing
	// ****************************************************************
	localparam int COL_PER_CARD = 80;
	localparam int COL_W = 12;
	localparam logic [11:0] HOLD_RST = 12'h000;
	localparam logic [15:0] RDATA_RST = 16'h0000;
	localparam real CLK_PERIOD_NS = 10.0;
	localparam real COL_PERIOD_MS = 6.5;
	localparam real EOR_HOLD_MS = 1.0;
	localparam int COL_CYCLES =
		int'($floor(COL_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int EOR_CYCLES =
		int'($floor(EOR_HOLD_MS * 1.0e6 / CLK_PERIOD_NS));

	typedef enum logic {S_IDLE, S_READ} rd_state_e;

endpackage : card_reader_pkg

// File: design/card_reader_controller.sv
`timescale 1ns/1ps

// Functional notes
// (RULE1) all 80 columns delivered, pause only at column 1, 6.5 ms apart
// (RULE2) raw binary column, bottom row bit 0, top row bit 11
// (RULE3) director address: write is function word, read is status word
// (RULE4) function bit 0 clears everything, then other bits apply
// (RULE5) function bit 1 clears interrupts, then selects in same word apply
// (RULE6) data interrupt while a column waits; ends on read or clears
// (RULE7) end of record interrupt; reader halts before next card till cleared
// (RULE8) alarm interrupt on four alarm causes; both clears drop it
// (RULE9) start feeds cards until stopped; mid-card start locks that card
// (RULE10) stop locks current card, halts at next card; stop beats start
// (RULE11) ready when powered, card registered, not manual mode
// (RULE12) busy while reading, never when not ready
// (RULE13) interrupt status when any selected condition is pending
// (RULE14) data status follows holding register, drops on column read
// (RULE15) end of record status after last column read, ends on clear or 1 ms
// (RULE16) alarm is OR of four causes, cleared only by master or ctrl clear
// (RULE17) column not taken in time sets lost data and locks the card
// (RULE18) protect status; with host protect on only protected ops accepted (code blocks only when the reader protect switch is also on)
// (RULE19) status bit 8 is zero when the reader is attached
// (RULE20) status bit 9 set when read station holds no card
// (RULE21) data read returns column in low 12 bits, rest zero
// (RULE22) host presents equipment address for every transfer
// (RULE23) master clear gives the same idle state as controller clear
module card_reader_controller #(
	parameter int COL_TICKS = card_reader_pkg::COL_CYCLES,
	parameter int EOR_TICKS = card_reader_pkg::EOR_CYCLES
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic host_mclr,
	input wire logic host_protect_sw,
	input wire logic [15:0] io_addr,
	input wire logic [15:0] io_wdata,
	input wire logic io_write,
	input wire logic io_read,
	input wire logic io_protected,
	output logic [15:0] io_rdata,
	output logic io_reply,
	output logic io_reject,
	output logic irq_request,
	input wire logic rdr_power_on,
	input wire logic rdr_card_present,
	input wire logic rdr_man_mode,
	input wire logic rdr_protect_sw,
	input wire logic rdr_attached,
	input wire logic [11:0] rdr_column,
	output logic rdr_feed
);

	localparam int TW = $clog2(COL_TICKS + 1);
	localparam int EW = $clog2(EOR_TICKS + 1);
	localparam int PW = card_reader_pkg::COL_W + 5;
	localparam logic [TW-1:0] COL_LOAD = TW'(COL_TICKS - 1);
	localparam logic [EW-1:0] EOR_LOAD = EW'(EOR_TICKS - 1);
	localparam logic [6:0] LAST_COL = 7'(card_reader_pkg::COL_PER_CARD - 1);

	if (COL_TICKS < 2 || EOR_TICKS < 2) begin : g_bad_param
		$error("timing parameters must be at least 2");
	end

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [PW-1:0] pin_s1;
	logic [PW-1:0] pin_s2;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= {rdr_power_on, rdr_card_present, rdr_man_mode,
				rdr_protect_sw, rdr_attached, rdr_column};
			pin_s2 <= pin_s1;
		end
	end

	logic power_s;
	logic card_s;
	logic man_s;
	logic prot_s;
	logic attached_s;
	logic [11:0] col_s;
	assign {power_s, card_s, man_s, prot_s, attached_s, col_s} = pin_s2;

	// ****************************************************************
	// state
	// ****************************************************************
	card_reader_pkg::rd_state_e state, next_state;
	logic [TW-1:0] timer, next_timer;
	logic [EW-1:0] eor_timer, next_eor_timer;
	logic [6:0] col_cnt, next_col_cnt;
	logic [11:0] hold, next_hold;
	logic data_full, next_data_full;
	logic last_col, next_last_col;
	logic motion, next_motion;
	logic stop_pending, next_stop_pending;
	logic xfer_lock, next_xfer_lock;
	logic lost, next_lost;
	logic alarm, next_alarm;
	logic alarm_irq, next_alarm_irq;
	logic eor, next_eor;
	logic eor_irq, next_eor_irq;
	logic sel_data, next_sel_data;
	logic sel_eor, next_sel_eor;
	logic sel_alarm, next_sel_alarm;
	logic [15:0] next_io_rdata;
	logic next_io_reply;
	logic next_io_reject;

	logic ready;
	logic busy;
	logic tick;
	logic deliver;
	logic hit;
	logic blocked;
	logic acc_wr_fn;
	logic acc_rd_st;
	logic acc_rd_data;
	logic acc_wr_data;
	logic [15:0] status;

	assign ready = power_s && card_s && !man_s; // (RULE11)
	// never busy while not ready, even mid-card
	assign busy = ready
		&& ((state == card_reader_pkg::S_READ) || motion); // (RULE12)
	assign tick = (state == card_reader_pkg::S_READ) && (timer == '0);
	assign deliver = tick && !xfer_lock && !data_full;
	assign hit = (io_read || io_write) && (io_addr == card_reader_pkg::DATA_ADDR
		|| io_addr == card_reader_pkg::DIR_ADDR); // (RULE22)
	assign blocked = host_protect_sw && prot_s && !io_protected; // (RULE18)
	assign acc_wr_fn = hit && !blocked && io_write
		&& io_addr == card_reader_pkg::DIR_ADDR; // (RULE3)
	assign acc_rd_st = hit && !blocked && io_read
		&& io_addr == card_reader_pkg::DIR_ADDR;
	assign acc_rd_data = hit && !blocked && io_read
		&& io_addr == card_reader_pkg::DATA_ADDR;
	assign acc_wr_data = hit && !blocked && io_write
		&& io_addr == card_reader_pkg::DATA_ADDR;
	assign irq_request = (sel_data && data_full)
		|| eor_irq || alarm_irq; // (RULE6)
	assign rdr_feed = (state == card_reader_pkg::S_READ);

	always_comb begin
		status = '0;
		status[card_reader_pkg::ST_READY] = ready;
		status[card_reader_pkg::ST_BUSY] = busy;
		status[card_reader_pkg::ST_INT] = irq_request; // (RULE13)
		status[card_reader_pkg::ST_DATA] = data_full; // (RULE14)
		status[card_reader_pkg::ST_EOR] = eor;
		status[card_reader_pkg::ST_ALARM] = alarm;
		status[card_reader_pkg::ST_LOST] = lost;
		status[card_reader_pkg::ST_PROTECT] = prot_s; // (RULE18)
		status[card_reader_pkg::ST_ABSENT] = !attached_s; // (RULE19)
		status[card_reader_pkg::ST_EMPTY] = !card_s; // (RULE20)
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	logic ev_alarm;
	logic ev_lost;
	logic clr_ctrl;
	logic clr_int;
	always_comb begin
		ev_alarm = 1'b0;
		ev_lost = 1'b0;
		next_state = state;
		next_timer = timer;
		next_eor_timer = eor_timer;
		next_col_cnt = col_cnt;
		next_hold = hold;
		next_data_full = data_full;
		next_last_col = last_col;
		next_motion = motion;
		next_stop_pending = stop_pending;
		next_xfer_lock = xfer_lock;
		next_lost = lost;
		next_alarm = alarm;
		next_alarm_irq = alarm_irq;
		next_eor = eor;
		next_eor_irq = eor_irq;
		next_sel_data = sel_data;
		next_sel_eor = sel_eor;
		next_sel_alarm = sel_alarm;
		next_io_rdata = io_rdata;
		next_io_reply = 1'b0;
		next_io_reject = hit && blocked;
		clr_ctrl = host_mclr || (acc_wr_fn && io_wdata[card_reader_pkg::FN_CLR_CTRL]);
		clr_int = acc_wr_fn && io_wdata[card_reader_pkg::FN_CLR_INT];
		// host reads, data writes and end of record timeout
		if (acc_rd_st) begin
			next_io_reply = 1'b1;
			next_io_rdata = status; // (RULE3)
		end
		if (acc_rd_data) begin
			next_io_reply = 1'b1;
			next_io_rdata = {4'h0, hold}; // (RULE21)
			next_data_full = 1'b0; // (RULE14)
			if (data_full && last_col) begin
				next_eor = 1'b1; // (RULE15)
				next_eor_timer = EOR_LOAD;
				next_eor_irq = sel_eor; // (RULE7)
			end
		end
		if (acc_wr_data) begin
			next_io_reply = 1'b1;
		end
		if (eor && !acc_rd_data) begin
			if (eor_timer == '0) begin
				next_eor = 1'b0; // (RULE15)
			end else begin
				next_eor_timer = eor_timer - 1'b1;
			end
		end
		// card motion
		case (state)
			card_reader_pkg::S_IDLE: begin
				if (motion) begin
					if (stop_pending || lost) begin
						next_motion = 1'b0; // (RULE10) (RULE17)
						next_stop_pending = 1'b0;
					end else if (!ready) begin
						ev_alarm = 1'b1; // (RULE16)
						next_motion = 1'b0;
					end else if (!eor_irq) begin // (RULE7)
						next_state = card_reader_pkg::S_READ;
						next_timer = COL_LOAD;
						next_col_cnt = '0;
						next_xfer_lock = 1'b0;
					end
				end
			end
			card_reader_pkg::S_READ: begin
				if (!power_s || man_s) begin
					ev_alarm = 1'b1; // (RULE16)
					next_motion = 1'b0;
					next_state = card_reader_pkg::S_IDLE;
				end else if (tick) begin
					next_timer = COL_LOAD; // (RULE1)
					next_col_cnt = col_cnt + 1'b1;
					if (deliver) begin
						next_hold = col_s; // (RULE2)
						next_data_full = 1'b1;
						next_last_col = (col_cnt == LAST_COL);
					end else if (!xfer_lock) begin
						ev_lost = 1'b1; // (RULE17)
						next_xfer_lock = 1'b1;
					end
					if (col_cnt == LAST_COL) begin
						next_state = card_reader_pkg::S_IDLE; // (RULE1)
					end
				end else begin
					next_timer = timer - 1'b1;
				end
			end
			default: next_state = card_reader_pkg::S_IDLE;
		endcase
		// clears come first within the function word
		if (clr_ctrl) begin
			next_state = card_reader_pkg::S_IDLE; // (RULE4) (RULE23)
			next_motion = 1'b0;
			next_stop_pending = 1'b0;
			next_xfer_lock = 1'b0;
			next_data_full = 1'b0;
			next_lost = 1'b0;
			next_alarm = 1'b0; // (RULE16)
		end
		if (clr_ctrl || clr_int) begin
			next_sel_data = 1'b0; // (RULE5)
			next_sel_eor = 1'b0;
			next_sel_alarm = 1'b0;
			next_eor = 1'b0;
			next_eor_irq = 1'b0;
			next_alarm_irq = 1'b0; // (RULE8)
		end
		if (acc_wr_fn) begin
			next_io_reply = 1'b1;
			if (io_wdata[card_reader_pkg::FN_SEL_DATA]) begin
				next_sel_data = 1'b1; // (RULE6)
			end
			if (io_wdata[card_reader_pkg::FN_SEL_EOR]) begin
				next_sel_eor = 1'b1;
				next_eor = 1'b0; // (RULE15)
			end
			if (io_wdata[card_reader_pkg::FN_SEL_ALARM]) begin
				next_sel_alarm = 1'b1;
			end
			if (io_wdata[card_reader_pkg::FN_STOP]) begin
				if (next_state == card_reader_pkg::S_READ) begin
					next_stop_pending = 1'b1; // (RULE10)
					next_xfer_lock = 1'b1;
				end else begin
					next_motion = 1'b0;
				end
			end else if (io_wdata[card_reader_pkg::FN_START]) begin
				if (next_state == card_reader_pkg::S_READ) begin
					next_xfer_lock = 1'b1; // (RULE9)
					next_motion = 1'b1;
				end else if (!ready) begin
					ev_alarm = 1'b1; // (RULE16)
				end else begin
					next_motion = 1'b1; // (RULE9)
				end
			end
		end
		// lost data and alarm events win over a clear in the same cycle
		if (ev_lost) begin
			next_lost = 1'b1;
		end
		if (ev_alarm || ev_lost) begin
			next_alarm = 1'b1;
			if (next_sel_alarm) begin
				next_alarm_irq = 1'b1; // (RULE8)
			end
		end
		if (tick && deliver && !clr_ctrl && state == card_reader_pkg::S_READ) begin
			next_data_full = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= card_reader_pkg::S_IDLE;
			timer <= '0;
			eor_timer <= '0;
			col_cnt <= '0;
			hold <= card_reader_pkg::HOLD_RST;
			data_full <= 1'b0;
			last_col <= 1'b0;
			motion <= 1'b0;
			stop_pending <= 1'b0;
			xfer_lock <= 1'b0;
			lost <= 1'b0;
			alarm <= 1'b0;
			alarm_irq <= 1'b0;
			eor <= 1'b0;
			eor_irq <= 1'b0;
			sel_data <= 1'b0;
			sel_eor <= 1'b0;
			sel_alarm <= 1'b0;
			io_rdata <= card_reader_pkg::RDATA_RST;
			io_reply <= 1'b0;
			io_reject <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			eor_timer <= next_eor_timer;
			col_cnt <= next_col_cnt;
			hold <= next_hold;
			data_full <= next_data_full;
			last_col <= next_last_col;
			motion <= next_motion;
			stop_pending <= next_stop_pending;
			xfer_lock <= next_xfer_lock;
			lost <= next_lost;
			alarm <= next_alarm;
			alarm_irq <= next_alarm_irq;
			eor <= next_eor;
			eor_irq <= next_eor_irq;
			sel_data <= next_sel_data;
			sel_eor <= next_sel_eor;
			sel_alarm <= next_sel_alarm;
			io_rdata <= next_io_rdata;
			io_reply <= next_io_reply;
			io_reject <= next_io_reject;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence s_col_tick;
		tick && !(!power_s || man_s) && !clr_ctrl;
	endsequence

	a_card_length: assert property (s_col_tick and col_cnt == LAST_COL // (RULE1)
		|=> state == card_reader_pkg::S_IDLE) else $error("card not ended");
	a_column_bits: assert property (s_col_tick and deliver // (RULE2)
		|=> data_full && hold == $past(col_s)) else $error("column not held");
	a_status_read: assert property (acc_rd_st // (RULE3)
		|=> io_reply && io_rdata == $past(status)) else $error("bad status");
	a_clear_ctrl: assert property (acc_wr_fn && io_wdata[0] // (RULE4)
		&& !io_wdata[5] |=> !motion && !xfer_lock) else $error("clear failed");
	a_stop_wins: assert property (acc_wr_fn && io_wdata[5] // (RULE10)
		&& io_wdata[6] |=> !motion || stop_pending)
		else $error("start beat stop");
	a_data_drop: assert property (acc_rd_data && !tick // (RULE14)
		|=> !data_full) else $error("data status stuck");
	a_data_word: assert property (acc_rd_data |=> io_reply // (RULE21)
		&& io_rdata == {4'h0, $past(hold)}) else $error("bad data word");
	a_eor_timeout: assert property (eor && eor_timer == '0 // (RULE15)
		&& !acc_rd_data |=> !eor) else $error("eor overstayed");
	a_lost_set: assert property (s_col_tick // (RULE17)
		and (!xfer_lock && data_full)
		|=> lost && alarm && xfer_lock) else $error("lost not flagged");
	a_protect_block: assert property (hit && blocked // (RULE18)
		|=> io_reject && !io_reply) else $error("protect ignored");
	a_master_clear: assert property (host_mclr && !ev_lost // (RULE23)
		|=> state == card_reader_pkg::S_IDLE && !motion && !lost)
		else $error("master clear failed");

endmodule : card_reader_controller

// File: bench/reader_mech_model.sv
`timescale 1ns/1ps
// ****
// card reader mechanism model
// ****
module reader_mech_model #(
	parameter int COL_TICKS = 20
) (
	input wire logic clk_sys,
	input wire logic rdr_feed,
	input wire logic power_cmd,
	input wire logic man_cmd,
	input wire logic card_cmd,
	output logic rdr_power_on,
	output logic rdr_man_mode,
	output logic rdr_card_present,
	output logic [11:0] rdr_column
);
	int cnt = 0;
	int pos;
	assign rdr_power_on = power_cmd;
	assign rdr_man_mode = man_cmd;
	assign rdr_card_present = card_cmd;
	// column k centred on the k-th capture tick of the card
	always @(posedge clk_sys) begin
		pos = (cnt + COL_TICKS / 2) / COL_TICKS;
		cnt <= rdr_feed ? cnt + 1 : 0;
		if (rdr_feed && pos > 0) begin
			rdr_column <= {4'((pos - 1) / 80), 8'((pos - 1) % 80 + 1)};
		end else begin
			// released lines: toggling, so the last column returns every other cycle
			rdr_column <= ~rdr_column;
		end
	end
	initial rdr_column = 12'h000;
endmodule : reader_mech_model

// File: bench/card_reader_controller_tb_top.sv
`timescale 1ns/1ps
module card_reader_controller_tb_top;
	localparam int T = 20;
	localparam int E = 10;
	localparam logic [15:0] DA = card_reader_pkg::DATA_ADDR;
	localparam logic [15:0] FA = card_reader_pkg::DIR_ADDR;
	logic clk_sys = 0;
	logic arst_n = 0;
	logic host_mclr = 0;
	logic host_protect_sw = 0;
	logic [15:0] io_addr = 16'h0000;
	logic [15:0] io_wdata = 16'h0000;
	logic io_write = 0;
	logic io_read = 0;
	logic io_protected = 0;
	logic rdr_protect_sw = 0;
	logic rdr_attached = 1;
	logic power_cmd = 1;
	logic man_cmd = 0;
	logic card_cmd = 1;
	logic [15:0] io_rdata;
	logic io_reply, io_reject, irq_request, rdr_feed;
	logic rdr_power_on, rdr_man_mode, rdr_card_present;
	logic [11:0] rdr_column;
	logic [15:0] rv;
	logic rep, rej;
	int fails = 0;
	int total_checks = 0;
	always #5 clk_sys = ~clk_sys;
	card_reader_controller #(.COL_TICKS(T), .EOR_TICKS(E)) dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .host_mclr(host_mclr),
		.host_protect_sw(host_protect_sw), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_write(io_write), .io_read(io_read),
		.io_protected(io_protected), .io_rdata(io_rdata),
		.io_reply(io_reply), .io_reject(io_reject),
		.irq_request(irq_request), .rdr_power_on(rdr_power_on),
		.rdr_card_present(rdr_card_present), .rdr_man_mode(rdr_man_mode),
		.rdr_protect_sw(rdr_protect_sw), .rdr_attached(rdr_attached),
		.rdr_column(rdr_column), .rdr_feed(rdr_feed));
	reader_mech_model #(.COL_TICKS(T)) mech (
		.clk_sys(clk_sys), .rdr_feed(rdr_feed), .power_cmd(power_cmd),
		.man_cmd(man_cmd), .card_cmd(card_cmd),
		.rdr_power_on(rdr_power_on), .rdr_man_mode(rdr_man_mode),
		.rdr_card_present(rdr_card_present), .rdr_column(rdr_column));
	// ****
	// host channel tasks
	// ****
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task chk(input logic [15:0] got, input logic [15:0] exp, input string s);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
		end
	endtask : chk
	task xfer(input logic [15:0] a, input logic [15:0] d, input logic w);
		cyc(1);
		io_addr = a;
		io_wdata = d;
		io_write = w;
		io_read = !w;
		cyc(1);
		rep = io_reply;
		rej = io_reject;
		rv = io_rdata;
		io_write = 0;
		io_read = 0;
		cyc(1);
	endtask : xfer
	task st();
		xfer(FA, 16'h0000, 1'b0);
	endtask : st
	task fn(input logic [15:0] d);
		xfer(FA, d, 1'b1);
	endtask : fn
	task read_card(input int c, input int n);
		int k;
		int w;
		for (k = 1; k <= n; k++) begin
			w = 0;
			do begin
				st();
				w++;
			end while (rv[3] !== 1'b1 && w < 40);
			xfer(DA, 16'h0000, 1'b0);
			chk(rv, {4'h0, 4'(c), 8'(k)}, "column");
			st();
			chk(rv[3], 1'b0, "data drop");
			if (k < 80) chk(irq_request, 1'b0, "irq drop");
		end
	endtask : read_card
	task wait_stop();
		int n;
		for (n = 0; n < 2000 && rdr_feed !== 1'b0; n++) cyc(1);
		chk(rdr_feed, 1'b0, "motion stop");
	endtask : wait_stop
	task conclude();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	initial begin
		cyc(30000);
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		conclude();
	end
	// ****
	// test sequence
	// ****
	initial begin
		int n;
		cyc(12);
		arst_n = 1;
		cyc(4);
		st();
		chk(rv, 16'h0001, "idle status");
		rdr_attached = 0;
		rdr_protect_sw = 1;
		card_cmd = 0;
		cyc(4);
		st();
		chk(rv, 16'h0380, "empty absent");
		rdr_attached = 1;
		card_cmd = 1;
		host_protect_sw = 1;
		cyc(4);
		fn(16'h0020);
		chk(rej, 1'b1, "reject");
		io_protected = 1;
		st();
		chk(rv, 16'h0081, "no start");
		chk(rep, 1'b1, "status reply");
		host_protect_sw = 0;
		rdr_protect_sw = 0;
		io_protected = 0;
		xfer(16'h00E5, 16'h0000, 1'b0);
		chk(rep, 1'b0, "unmapped");
		$display("test status and protect done");
		fn(16'h0024);
		for (n = 0; n < 60 && irq_request !== 1'b1; n++) cyc(1);
		chk(irq_request, 1'b1, "data irq");
		st();
		chk(rv & 16'h000F, 16'h000F, "reading");
		read_card(0, 80);
		st();
		chk(rv[4], 1'b1, "eor set");
		cyc(E);
		st();
		chk(rv[4], 1'b0, "eor timeout");
		read_card(0, 3);
		fn(16'h0040);
		cyc(3 * T);
		st();
		chk(rv & 16'h0048, 16'h0000, "locked");
		chk(rdr_feed, 1'b1, "card moves on");
		wait_stop();
		st();
		chk(rv[1], 1'b0, "not busy");
		$display("test card read done");
		fn(16'h0028);
		read_card(0, 80);
		chk(irq_request, 1'b1, "eor irq");
		st();
		chk(rv & 16'h0014, 16'h0014, "eor int");
		fn(16'h0041);
		chk(irq_request, 1'b0, "ctrl clear irq");
		wait_stop();
		st();
		chk(rv & 16'h007E, 16'h0000, "ctrl clear");
		$display("test end of record done");
		fn(16'h0030);
		cyc(3 * T);
		st();
		chk(rv & 16'h0064, 16'h0064, "lost");
		chk(irq_request, 1'b1, "alarm irq");
		fn(16'h0002);
		chk(irq_request, 1'b0, "int clear");
		st();
		chk(rv & 16'h0064, 16'h0060, "alarm kept");
		wait_stop();
		fn(16'h0001);
		st();
		chk(rv & 16'h0060, 16'h0000, "alarm clear");
		$display("test lost data done");
		power_cmd = 0;
		cyc(4);
		fn(16'h0020);
		st();
		chk(rv & 16'h0023, 16'h0020, "start not ready");
		host_mclr = 1;
		cyc(1);
		host_mclr = 0;
		power_cmd = 1;
		cyc(4);
		st();
		chk(rv & 16'h0063, 16'h0001, "master clear");
		fn(16'h0060);
		cyc(4);
		chk(rdr_feed, 1'b0, "stop wins");
		fn(16'h0021);
		cyc(3);
		st();
		chk(rv & 16'h0003, 16'h0003, "clear then start");
		fn(16'h0020);
		cyc(3 * T);
		st();
		chk(rv & 16'h0048, 16'h0000, "start locks card");
		chk(rdr_feed, 1'b1, "locked card moves");
		cyc(80 * T);
		st();
		chk(rv[3], 1'b1, "next card resumes");
		man_cmd = 1;
		cyc(6);
		st();
		chk(rv & 16'h0023, 16'h0020, "manual abort");
		man_cmd = 0;
		$display("test clears and readiness done");
		conclude();
	end
endmodule : card_reader_controller_tb_top
